// ### dpfs_pkg.sv
// package: timing constants and state types for the dual port fault supervisor
package dpfs_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned ONTIME_WIN_NS   = 10_000;
  localparam int unsigned LS_PULSE_NS     = 150;
  localparam int unsigned SOFTSTART_MS    = 8;
  localparam int unsigned CL_RESET_MS     = 16;
  localparam int unsigned DEBOUNCE_MS     = 2;
  localparam int unsigned THERM_DEB_MS    = 1;
  localparam int unsigned RETRY_MS        = 2000;
  localparam int unsigned TICK_US         = 1000;
  // fixed internal tick of 1 ms; all long intervals count ticks
  localparam int unsigned TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned ONTIME_WIN_CYC  = ONTIME_WIN_NS / CLK_PERIOD_NS;
  // least time: round up
  localparam int unsigned LS_PULSE_CYC    = (LS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SOFTSTART_TICKS = SOFTSTART_MS;
  localparam int unsigned CL_RESET_TICKS  = CL_RESET_MS;
  localparam int unsigned DEBOUNCE_TICKS  = DEBOUNCE_MS;
  localparam int unsigned THERM_TICKS     = THERM_DEB_MS;
  localparam int unsigned RETRY_TICKS     = RETRY_MS;
  localparam int unsigned TICK_W          = 12;

  typedef enum logic [2:0] {DPFS_SHUTDOWN, DPFS_WAIT_BIAS, DPFS_SOFTSTART, DPFS_RUN,
                            DPFS_CL_RESET, DPFS_THERMAL} dpfs_conv_e;
  typedef enum logic [1:0] {DPFS_P_ON, DPFS_P_DEBOUNCE, DPFS_P_FAULT, DPFS_P_RETRY} dpfs_port_e;
endpackage

// ### dpfs_port_if.sv
// interface: per-port fault inputs and switch controls
interface dpfs_port_if;
  logic uv_trip;
  logic oc_trip;
  logic retry_above;
  logic global_hold;
  logic tick;
  logic switch_on;
  logic data_sw_on;
  logic det_reset;
  logic diag_src_on;
  modport port_ctl (input uv_trip, oc_trip, retry_above, global_hold, tick,
                    output switch_on, data_sw_on, det_reset, diag_src_on);
  modport top (output uv_trip, oc_trip, retry_above, global_hold, tick,
               input switch_on, data_sw_on, det_reset, diag_src_on);
endinterface

// ### dpfs_port_ctl.sv
// per-port bus protection: short to ground, overcurrent and undervoltage retry
module dpfs_port_ctl
  import dpfs_pkg::*;
#(
  parameter int unsigned DEB_TICKS   = dpfs_pkg::DEBOUNCE_TICKS,
  parameter int unsigned RETRY_TICKS = dpfs_pkg::RETRY_TICKS
)(
  input  wire logic      i_clk_sys,
  input  wire logic      i_sys_rst,
  dpfs_port_if.port_ctl  p
);
  import dpfs_pkg::*;
  dpfs_port_e         st_reg;
  dpfs_port_e         st_next;
  logic [TICK_W-1:0]  cnt_reg;
  logic [TICK_W-1:0]  cnt_next;
  logic               short_reg;
  logic               short_next;

  wire debounced_fault = p.oc_trip;
  wire deb_done = p.tick && (cnt_reg == TICK_W'(DEB_TICKS - 1));
  wire ret_done = p.tick && (cnt_reg == TICK_W'(RETRY_TICKS - 1));

  always_comb
  begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    short_next = short_reg;
    case (st_reg)
      DPFS_P_ON:
      begin
        cnt_next = '0;
        if (p.uv_trip)
        begin
          // short to ground acts at once, no debounce
          st_next    = DPFS_P_FAULT;
          short_next = 1'b1;
        end
        else if (debounced_fault)
          st_next = DPFS_P_DEBOUNCE;
      end
      DPFS_P_DEBOUNCE:
      begin
        if (p.uv_trip)
        begin
          st_next    = DPFS_P_FAULT;
          short_next = 1'b1;
          cnt_next   = '0;
        end
        else if (!debounced_fault)
        begin
          st_next  = DPFS_P_ON;
          cnt_next = '0;
        end
        else if (deb_done)
        begin
          st_next    = DPFS_P_FAULT;
          short_next = 1'b0;
          cnt_next   = '0;
        end
        else if (p.tick)
          cnt_next = cnt_reg + 1'b1;
      end
      DPFS_P_FAULT:
      begin
        cnt_next = '0;
        // short waits for the retry comparator; others go straight to retry
        if (!short_reg || p.retry_above)
          st_next = DPFS_P_RETRY;
      end
      default:
      begin
        if (short_reg && !p.retry_above)
        begin
          st_next  = DPFS_P_FAULT;
          cnt_next = '0;
        end
        else if (ret_done)
        begin
          cnt_next = '0;
          // a fault still present reapplies the actions with a fresh retry
          if (p.uv_trip || debounced_fault)
          begin
            st_next    = DPFS_P_FAULT;
            short_next = p.uv_trip;
          end
          else
          begin
            st_next    = DPFS_P_ON;
            short_next = 1'b0;
          end
        end
        else if (p.tick)
          cnt_next = cnt_reg + 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_reg    <= DPFS_P_ON;
      cnt_reg   <= '0;
      short_reg <= 1'b0;
    end
    else
    begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      short_reg <= short_next;
    end
  end

  wire port_ok = (st_reg == DPFS_P_ON) || (st_reg == DPFS_P_DEBOUNCE);
  // undervoltage opens the switch in the same cycle
  assign p.switch_on   = port_ok && !p.uv_trip && !p.global_hold;
  assign p.data_sw_on  = port_ok && !p.uv_trip && !p.global_hold;
  assign p.det_reset   = !port_ok || p.uv_trip || p.global_hold;
  assign p.diag_src_on = short_reg && !port_ok;

  a_uv_opens_switch: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    p.uv_trip |-> !p.switch_on && !p.data_sw_on) else $error("switch on under uv");
  a_uv_diag_src: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (st_reg == DPFS_P_ON && p.uv_trip) |=> p.diag_src_on) else $error("no diag source");
  a_oc_debounce_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (st_reg == DPFS_P_ON && !p.uv_trip && p.oc_trip) |=> st_reg == DPFS_P_DEBOUNCE)
    else $error("oc not debounced");
endmodule

// ### dpfs_top.sv
// top: converter sequencing, duty limit, gate drive and global fault handling
// Function
// - enable low shuts down regulator and gate drivers; high leaves shutdown.
// - converter starts only after bias lockout clears, then soft-starts.
// - continuous on-time for the window forces a short low-side pulse each window.
// - current limit turns high side off until valley; restart next cycle if output high.
// - current limit with low output resets converter 16 ms, then retries soft-start.
// - thermal trip shuts converter down until temperature drops 15 degrees.
// - bus overvoltage on either port drops gate drive and enables discharge.
// - after overvoltage, wait 2 s, raise gate, retest; repeat every 2 s.
// - port undervoltage opens that switch at once and connects diagnostic source.
// - short recovery starts 2 s timer once retry comparator is above threshold.
// - foldback reduces current; retry after 2 s once temperature drops.
// - bus protection is two identical independent per-port instances.
// - global faults disable port switches, data switches and gate at once and re-enable after 2 s; the converter keeps running.
// - port short disables that switch and its data switch at once, retries 2 s.
// - port overcurrent lasting 2 ms disables port, retries 2 s; undervoltage disables it at once.
// - soft-start ramps the output over about 8 ms.
// - thermal shutdown debounced 1 ms, disables ports and gate, then restarts.
module dpfs_top
  import dpfs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = dpfs_pkg::TICK_CYC,
  parameter int unsigned RETRY_T     = dpfs_pkg::RETRY_TICKS
)(
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  // enable and converter comparators
  input  wire logic i_system_enable_pin,
  input  wire logic i_bias_lockout_level,
  input  wire logic i_hs_on,
  input  wire logic i_conv_ilim,
  input  wire logic i_conv_valley,
  input  wire logic i_out_above_2v5,
  input  wire logic i_thermal_trip,
  input  wire logic i_thermal_cool,
  input  wire logic i_foldback_trip,
  // bus and global fault comparators
  input  wire logic [1:0] i_bus_overvoltage_level,
  input  wire logic [1:0] i_bus_undervoltage_level,
  input  wire logic [1:0] i_port_overcurrent,
  input  wire logic [1:0] i_retry_above,
  input  wire logic i_data_line_ov,
  input  wire logic i_src_short_batt,
  input  wire logic i_switch_supply_rail_uv,
  // converter controls
  output logic o_ldo_en,
  output logic o_conv_reset,
  output logic o_softstart_run,
  output logic o_hs_allow,
  output logic o_ls_force,
  output logic o_foldback_ilim,
  // gate and port controls
  output logic o_external_gate_drive,
  output logic o_gate_discharge,
  output logic [1:0] o_port_switch_on,
  output logic [1:0] o_data_switch_on,
  output logic [1:0] o_det_reset,
  output logic [1:0] o_diag_src_on
);
  import dpfs_pkg::*;

  dpfs_conv_e         cst_reg;
  dpfs_conv_e         cst_next;
  logic [15:0]        tdiv_reg;
  logic               tick_reg;
  logic [TICK_W-1:0]  ccnt_reg;
  logic [TICK_W-1:0]  ccnt_next;
  logic [7:0]         ont_reg;
  logic [1:0]         lsp_reg;
  logic               hs_block_reg;
  logic               ov_hold_reg;
  logic [TICK_W-1:0]  ov_cnt_reg;
  logic               gl_hold_reg;
  logic [TICK_W-1:0]  gl_cnt_reg;
  logic               fb_reg;
  logic [TICK_W-1:0]  fb_cnt_reg;
  logic [TICK_W-1:0]  th_deb_reg;

  // fixed internal time base
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tdiv_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= (tdiv_reg == 16'(TICK_CYCLES - 1));
      tdiv_reg <= (tdiv_reg == 16'(TICK_CYCLES - 1)) ? '0 : tdiv_reg + 1'b1;
    end
  end

  // converter sequencing
  wire thermal_deb  = i_thermal_trip && tick_reg && (th_deb_reg == TICK_W'(THERM_TICKS - 1));
  wire low_out_ilim = i_conv_ilim && !i_out_above_2v5;
  wire cc_tick_end  = tick_reg && (ccnt_reg == TICK_W'(SOFTSTART_TICKS - 1));
  wire cl_tick_end  = tick_reg && (ccnt_reg == TICK_W'(CL_RESET_TICKS - 1));
  wire conv_active  = (cst_reg == DPFS_SOFTSTART) || (cst_reg == DPFS_RUN);

  always_comb
  begin
    cst_next  = cst_reg;
    ccnt_next = tick_reg ? ccnt_reg + 1'b1 : ccnt_reg;
    case (cst_reg)
      DPFS_SHUTDOWN:
      begin
        ccnt_next = '0;
        if (i_system_enable_pin)
          cst_next = DPFS_WAIT_BIAS;
      end
      DPFS_WAIT_BIAS:
      begin
        ccnt_next = '0;
        if (i_bias_lockout_level)
          cst_next = DPFS_SOFTSTART;
      end
      DPFS_SOFTSTART:
        if (low_out_ilim)
        begin
          cst_next  = DPFS_CL_RESET;
          ccnt_next = '0;
        end
        else if (cc_tick_end)
        begin
          // output still low at soft-start end: reset and try again
          cst_next  = i_out_above_2v5 ? DPFS_RUN : DPFS_CL_RESET;
          ccnt_next = '0;
        end
      DPFS_RUN:
      begin
        ccnt_next = '0;
        if (low_out_ilim)
          cst_next = DPFS_CL_RESET;
      end
      DPFS_CL_RESET:
        if (cl_tick_end)
        begin
          cst_next  = DPFS_SOFTSTART;
          ccnt_next = '0;
        end
      default:
      begin
        ccnt_next = '0;
        if (i_thermal_cool)
          cst_next = DPFS_WAIT_BIAS;
      end
    endcase
    if (thermal_deb && cst_reg != DPFS_THERMAL)
    begin
      cst_next  = DPFS_THERMAL;
      ccnt_next = '0;
    end
    if (!i_system_enable_pin)
    begin
      cst_next  = DPFS_SHUTDOWN;
      ccnt_next = '0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cst_reg  <= DPFS_SHUTDOWN;
      ccnt_reg <= '0;
    end
    else
    begin
      cst_reg  <= cst_next;
      ccnt_reg <= ccnt_next;
    end
  end

  // thermal debounce restarts whenever the trip drops
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      th_deb_reg <= '0;
    else if (!i_thermal_trip || thermal_deb)
      th_deb_reg <= '0;
    else if (tick_reg)
      th_deb_reg <= th_deb_reg + 1'b1;
  end

  // duty limit: continuous on-time for the window forces a low-side pulse
  wire ont_full = (ont_reg == 8'(ONTIME_WIN_CYC - 1));
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ont_reg <= '0;
      lsp_reg <= '0;
    end
    else
    begin
      ont_reg <= (!i_hs_on || ont_full) ? '0 : ont_reg + 1'b1;
      lsp_reg <= ont_full ? 2'(LS_PULSE_CYC) : (lsp_reg != '0 ? lsp_reg - 1'b1 : '0);
    end
  end

  // cycle-by-cycle current limit, held until valley is crossed
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      hs_block_reg <= 1'b0;
    else if (i_conv_ilim)
      hs_block_reg <= 1'b1;
    else if (i_conv_valley)
      hs_block_reg <= 1'b0;
  end

  // bus overvoltage: shared gate, retry every 2 s
  wire ov_any  = |i_bus_overvoltage_level;
  wire ov_done = ov_hold_reg && tick_reg && (ov_cnt_reg == TICK_W'(RETRY_T - 1));
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ov_hold_reg <= 1'b0;
      ov_cnt_reg  <= '0;
    end
    else if (ov_any && !ov_hold_reg)
    begin
      ov_hold_reg <= 1'b1;
      ov_cnt_reg  <= '0;
    end
    else if (ov_hold_reg)
    begin
      // gate goes high on expiry; a persisting trip re-latches next cycle
      ov_hold_reg <= !ov_done;
      ov_cnt_reg  <= ov_done ? '0 : (tick_reg ? ov_cnt_reg + 1'b1 : ov_cnt_reg);
    end
  end

  // global faults, no debounce; thermal shutdown joins them
  wire gl_fault = i_data_line_ov || i_src_short_batt || i_switch_supply_rail_uv;
  wire gl_done  = tick_reg && (gl_cnt_reg == TICK_W'(RETRY_T - 1));
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      gl_hold_reg <= 1'b0;
      gl_cnt_reg  <= '0;
    end
    else if (gl_fault)
    begin
      gl_hold_reg <= 1'b1;
      gl_cnt_reg  <= '0;
    end
    else if (gl_hold_reg)
    begin
      gl_hold_reg <= !gl_done;
      gl_cnt_reg  <= gl_done ? '0 : (tick_reg ? gl_cnt_reg + 1'b1 : gl_cnt_reg);
    end
  end

  // foldback: hold ports off while hot, retry 2 s after cooling
  wire fb_done = tick_reg && (fb_cnt_reg == TICK_W'(RETRY_T - 1));
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      fb_reg     <= 1'b0;
      fb_cnt_reg <= '0;
    end
    else if (i_foldback_trip)
    begin
      fb_reg     <= 1'b1;
      fb_cnt_reg <= '0;
    end
    else if (fb_reg)
    begin
      fb_reg     <= !fb_done;
      fb_cnt_reg <= fb_done ? '0 : (tick_reg ? fb_cnt_reg + 1'b1 : fb_cnt_reg);
    end
  end

  wire all_hold = gl_fault || gl_hold_reg || fb_reg || cst_reg == DPFS_THERMAL
                  || !i_system_enable_pin;

  // two identical independent port instances
  dpfs_port_if pif [2] ();
  genvar g;
  for (g = 0; g < 2; g++)
  begin : g_port
    assign pif[g].uv_trip     = i_bus_undervoltage_level[g];
    assign pif[g].oc_trip     = i_port_overcurrent[g];
    assign pif[g].retry_above = i_retry_above[g];
    assign pif[g].global_hold = all_hold;
    assign pif[g].tick        = tick_reg;
    assign o_port_switch_on[g] = pif[g].switch_on;
    assign o_data_switch_on[g] = pif[g].data_sw_on;
    assign o_det_reset[g]      = pif[g].det_reset;
    assign o_diag_src_on[g]    = pif[g].diag_src_on;
    dpfs_port_ctl #(.RETRY_TICKS(RETRY_T)) u_port (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .p         (pif[g])
    );
  end

  assign o_ldo_en         = i_system_enable_pin;
  assign o_conv_reset     = !conv_active;
  assign o_softstart_run  = (cst_reg == DPFS_SOFTSTART);
  assign o_hs_allow       = conv_active && !hs_block_reg && !i_conv_ilim;
  assign o_ls_force       = conv_active && (lsp_reg != '0);
  assign o_foldback_ilim  = fb_reg;
  // expiry lifts the gate for one cycle so a persisting trip is retested
  wire ov_block = (ov_any || ov_hold_reg) && !ov_done;
  assign o_external_gate_drive = i_system_enable_pin && !ov_block && !all_hold;
  assign o_gate_discharge = ov_block;

  sequence s_ov_hit;
    ov_any && !ov_hold_reg;
  endsequence
  a_ov_gate_low: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (ov_any && !ov_done) |-> !o_external_gate_drive && o_gate_discharge)
    else $error("gate on at ov");
  a_ov_retest: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (ov_done && !all_hold && i_system_enable_pin) |-> o_external_gate_drive)
    else $error("gate not raised for retest");
  a_ov_retry_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_ov_hit |=> ov_hold_reg [*8]) else $error("ov hold too short");
  a_enable_low_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !i_system_enable_pin |-> !o_ldo_en ##1 cst_reg == DPFS_SHUTDOWN) else $error("no shutdown");
  a_bias_gate: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (cst_reg == DPFS_WAIT_BIAS && !i_bias_lockout_level) |=> cst_reg != DPFS_SOFTSTART)
    else $error("start without bias");
  a_ilim_hs_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_conv_ilim |-> !o_hs_allow ##1 (!o_hs_allow || i_conv_valley)) else $error("hs on in ilim");
  a_low_ilim_reset: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (cst_reg == DPFS_RUN && low_out_ilim && i_system_enable_pin && !thermal_deb)
    |=> cst_reg == DPFS_CL_RESET) else $error("no 16ms reset");
  a_ls_pulse: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (ont_full && conv_active) |=> o_ls_force || !conv_active) else $error("no ls pulse");
  a_global_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    gl_fault |-> o_port_switch_on == 2'b00 && !o_external_gate_drive && o_det_reset == 2'b11)
    else $error("global fault not applied");
  a_thermal_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    cst_reg == DPFS_THERMAL |-> o_conv_reset && o_port_switch_on == 2'b00)
    else $error("thermal not applied");
endmodule

// ### dpfs_far_model.sv
// model: external pass transistors, bus comparators and port connectors
module dpfs_far_model
  import dpfs_pkg::*;
(
  // fault injection from the bench
  input  wire logic [1:0] i_short_gnd,
  input  wire logic [1:0] i_short_batt,
  // device controls
  input  wire logic [1:0] i_diag_src_on,
  // comparator results
  output logic [1:0]      o_bus_uv,
  output logic [1:0]      o_bus_ov,
  output logic [1:0]      o_retry_above
);
  timeunit 1ns;
  timeprecision 1ns;
  import dpfs_pkg::*;
  // a grounded bus sits below the undervoltage level whatever the switch does
  assign o_bus_uv      = i_short_gnd;
  assign o_bus_ov      = i_short_batt;
  // diagnostic current lifts the node only once the short is gone
  assign o_retry_above = i_diag_src_on & ~i_short_gnd;
endmodule

// ### tb.sv
// testbench: fault supervisor sequencing and per-port protection
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dpfs_pkg::*;
  localparam int unsigned TK = 10;
  localparam int unsigned RT = 4;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, bias = 1'b0, hs_on = 1'b0, ilim = 1'b0;
  logic valley = 1'b0, out_hi = 1'b0, t_trip = 1'b0, t_cool = 1'b0, fb = 1'b0;
  logic [1:0] gnd_s = 2'h0, batt_s = 2'h0, oc = 2'h0, uv, ov, rty;
  logic [2:0] glob = 3'h0;
  logic ldo, crst, ss, hsa, lsf, fbi, gate, dis;
  logic [1:0] psw, dsw, detr, diag;
  wire  [15:0] obs = {diag, detr, dsw, psw, dis, gate, fbi, lsf, hsa, ss, crst, ldo};
  int error_cnt = 0, num_checks = 0;
  always #50 clk = ~clk;
  dpfs_top #(.TICK_CYCLES(TK), .RETRY_T(RT)) uut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_system_enable_pin(en), .i_bias_lockout_level(bias),
    .i_hs_on(hs_on), .i_conv_ilim(ilim), .i_conv_valley(valley), .i_out_above_2v5(out_hi),
    .i_thermal_trip(t_trip), .i_thermal_cool(t_cool), .i_foldback_trip(fb),
    .i_bus_overvoltage_level(ov), .i_bus_undervoltage_level(uv), .i_port_overcurrent(oc),
    .i_retry_above(rty), .i_data_line_ov(glob[0]), .i_src_short_batt(glob[1]),
    .i_switch_supply_rail_uv(glob[2]), .o_ldo_en(ldo), .o_conv_reset(crst),
    .o_softstart_run(ss), .o_hs_allow(hsa), .o_ls_force(lsf), .o_foldback_ilim(fbi),
    .o_external_gate_drive(gate), .o_gate_discharge(dis), .o_port_switch_on(psw),
    .o_data_switch_on(dsw), .o_det_reset(detr), .o_diag_src_on(diag));
  dpfs_far_model far (.i_short_gnd(gnd_s), .i_short_batt(batt_s), .i_diag_src_on(diag),
    .o_bus_uv(uv), .o_bus_ov(ov), .o_retry_above(rty));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [1:0] exp, input logic [1:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", n, exp, got);
    end
  endtask
  // waits at falling edges for one observed bit; the count must land in [lo,hi]
  task automatic wait_bit(input string n, input int i, input logic v, input int lo, input int hi);
    int c;
    c = 0;
    while (obs[i] !== v && c <= hi)
    begin
      @(negedge clk);
      c++;
    end
    num_checks++;
    if (c < lo || c > hi)
    begin
      error_cnt++;
      $display("ERROR %s expected %0d..%0d cycles seen %0d", n, lo, hi, c);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("ERROR watchdog expected done seen hang");
    complete_run();
  end
  initial
  begin
    cyc(8);
    rst <= 1'b0;
    @(negedge clk);
    chk("ldo_off", 2'h0, {1'b0, ldo});
    chk("conv_rst", 2'h1, {1'b0, crst});
    cyc(1);
    en <= 1'b1;
    cyc(50);
    @(negedge clk);
    chk("ss_wait_bias", 2'h0, {1'b0, ss});
    chk("ports_on", 2'h3, psw);
    chk("gate_on", 2'h1, {1'b0, gate});
    @(posedge clk) bias <= 1'b1;
    wait_bit("ss_start", 2, 1'b1, 0, 3);
    @(posedge clk) out_hi <= 1'b1;
    wait_bit("ss_len", 2, 1'b0, 70, 92);
    cyc(2);
    @(negedge clk) chk("run", 2'h0, {1'b0, crst});
    $display("test startup done");
    @(posedge clk) ilim <= 1'b1;
    wait_bit("hs_off", 3, 1'b0, 0, 2);
    @(posedge clk) begin ilim <= 1'b0; valley <= 1'b1; end
    wait_bit("hs_back", 3, 1'b1, 0, 3);
    chk("no_reset_hi_out", 2'h0, {1'b0, crst});
    @(posedge clk) begin valley <= 1'b0; out_hi <= 1'b0; ilim <= 1'b1; end
    @(posedge clk) ilim <= 1'b0;
    wait_bit("cl_reset", 1, 1'b1, 0, 2);
    wait_bit("cl_hold", 2, 1'b1, 150, 172);
    wait_bit("ss_len2", 2, 1'b0, 70, 92);
    cyc(2);
    @(negedge clk) chk("retry_low_out", 2'h1, {1'b0, crst});
    @(posedge clk) out_hi <= 1'b1;
    wait_bit("cl_hold2", 2, 1'b1, 140, 172);
    wait_bit("ss_len3", 2, 1'b0, 70, 92);
    cyc(2);
    @(negedge clk) chk("run2", 2'h0, {1'b0, crst});
    $display("test current limit done");
    @(posedge clk) hs_on <= 1'b1;
    wait_bit("ls_first", 4, 1'b1, 90, 110);
    wait_bit("ls_pulse", 4, 1'b0, 1, 3);
    wait_bit("ls_period", 4, 1'b1, 94, 100);
    @(posedge clk) hs_on <= 1'b0;
    $display("test duty limit done");
    @(posedge clk) t_trip <= 1'b1;
    wait_bit("therm_deb", 1, 1'b1, 1, 22);
    cyc(1);
    @(negedge clk) chk("therm_ports", 2'h0, psw);
    chk("therm_gate", 2'h0, {1'b0, gate});
    @(posedge clk) begin t_trip <= 1'b0; t_cool <= 1'b1; end
    wait_bit("therm_restart", 2, 1'b1, 0, 30);
    @(posedge clk) t_cool <= 1'b0;
    wait_bit("therm_ss", 2, 1'b0, 70, 92);
    cyc(50);
    $display("test thermal done");
    @(posedge clk) batt_s <= 2'h1;
    @(negedge clk) chk("ov_gate", 2'h2, {dis, gate});
    wait_bit("ov_retry", 6, 1'b1, 30, 52);
    wait_bit("ov_relatch", 6, 1'b0, 1, 2);
    @(posedge clk) batt_s <= 2'h0;
    wait_bit("ov_clear", 6, 1'b1, 30, 52);
    cyc(1);
    @(negedge clk) chk("ov_dis_off", 2'h0, {1'b0, dis});
    $display("test overvoltage done");
    @(posedge clk) gnd_s <= 2'h1;
    @(negedge clk) chk("uv_port", 2'h2, psw);
    wait_bit("uv_diag", 14, 1'b1, 0, 2);
    chk("uv_det_ds", 2'h1, {dsw[0], detr[0]});
    cyc(30);
    @(posedge clk) gnd_s <= 2'h0;
    wait_bit("uv_retry", 8, 1'b1, 30, 52);
    chk("uv_diag_off", 2'h0, diag);
    $display("test short to ground done");
    @(posedge clk) oc <= 2'h2;
    cyc(8);
    oc <= 2'h0;
    cyc(2);
    oc <= 2'h2;
    cyc(8);
    oc <= 2'h0;
    @(negedge clk) chk("oc_restart", 2'h3, psw);
    @(posedge clk) oc <= 2'h2;
    wait_bit("oc_deb", 9, 1'b0, 10, 32);
    chk("oc_other", 2'h1, {dsw[1], psw[0]});
    @(posedge clk) oc <= 2'h0;
    wait_bit("oc_retry", 9, 1'b1, 30, 52);
    $display("test overcurrent done");
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk) glob <= 3'h1 << k;
      @(negedge clk) chk("glob_sw", 2'h0, psw | dsw);
      chk("glob_gate_det", 2'h3, {~gate, detr[0] & detr[1]});
      @(posedge clk) glob <= 3'h0;
      wait_bit("glob_retry", 6, 1'b1, 30, 52);
      cyc(2);
    end
    $display("test global faults done");
    @(posedge clk) fb <= 1'b1;
    wait_bit("fb_set", 5, 1'b1, 0, 250);
    @(negedge clk) chk("fb_ports", 2'h0, psw);
    @(posedge clk) fb <= 1'b0;
    wait_bit("fb_retry", 8, 1'b1, 30, 52);
    chk("fb_clear", 2'h0, {1'b0, fbi});
    $display("test foldback done");
    @(posedge clk) en <= 1'b0;
    @(negedge clk) chk("shutdown_ldo", 2'h0, {1'b0, ldo});
    wait_bit("shutdown_conv", 1, 1'b1, 0, 2);
    $display("test shutdown done");
    complete_run();
  end
endmodule
